// ### relay_map.vh
`ifndef RELAY_MAP_VH
`define RELAY_MAP_VH

// word and channel geometry
`define RD_WORD_W 8
`define RD_SEL_W 3
`define RD_PAR_W 4
`define RD_PAR_LVL_BIT 3

// command queue
`define RD_FIFO_DEPTH 32
`define RD_FIFO_AW 5
`define RD_CMD_W 9
`define RD_CMD_KIND_BIT 8

// forced states and reset values
`define RD_ALL_ON 8'hff
`define RD_ALL_OFF 8'h00
`define RD_PAR_ON 4'hf
`define RD_PAR_OFF 4'h0

// pin synchroniser: bit order and idle levels
`define RD_PIN_W 10
`define RD_PIN_SCLK 0
`define RD_PIN_CS 1
`define RD_PIN_DIN 2
`define RD_PIN_SEL0 3
`define RD_PIN_LVL 6
`define RD_PIN_SET 7
`define RD_PIN_CLR 8
`define RD_PIN_MODE 9
`define RD_PIN_IDLE 10'h182

`endif

// ### relay_sync.v
// two-stage synchroniser for a group of unrelated pins
module relay_sync #(
    parameter W = 1,
    parameter [W-1:0] IDLE = {W{1'b0}}
) (
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] pin_in,
    output wire [W-1:0] pin_sync
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_q;
            reg stable_q;
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_q <= IDLE[i];
                    stable_q <= IDLE[i];
                end else begin
                    meta_q <= pin_in[i];
                    stable_q <= meta_q;
                end
            end
            assign pin_sync[i] = stable_q;
        end
    endgenerate
endmodule

// ### relay_fifo.v
// synchronous queue with valid/ready on both sides and a flush
module relay_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk,
    input wire rst_n,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rd_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// ### relay_driver.v
// Notes on behaviour
// - eight-bit shift register; bit 7 drives channel 8, bit 0 channel 1
// - with chip select low, data is sampled on each serial clock rise
// - chip select rising copies the shift register into the output latch; here via a queue, held by update_hold, dropped when full
// - serial out shows the last stage, changing on serial clock falls
// - words travel msb first, both in and out
// - outputs keep their latched state while shifting with chip select low
// - with chip select high, serial clock and data are ignored
// - with chip select high, serial out shows the word's msb
// - after any bit count, only the last eight bits are held
// - latch update on chip select rise whatever the serial clock level
// - parallel: three select bits pick a channel, level turns it on or off
// - parallel: with chip select high, select and level have no effect
// - parallel: chip select fall captures select/level, the rise updates one channel
// - parallel: select data changed after chip select falls is not used
// - select bits form a binary index, bit 2 msb, index 0 is channel 1
// - set input low forces all latches and registers to one
// - clear input low forces all to zero and beats set
// - a channel at one pulls to power ground, at zero it floats
`include "relay_map.vh"

module relay_driver #(
    parameter DEPTH = `RD_FIFO_DEPTH,
    parameter AW = `RD_FIFO_AW
) (
    input wire clk,
    input wire rst_n,
    input wire serial_clk,
    input wire chip_sel_n,
    input wire serial_din,
    input wire channel_sel_bit0,
    input wire channel_sel_bit1,
    input wire channel_sel_bit2,
    input wire switch_level,
    input wire set_all_n,
    input wire clear_all_n,
    input wire parallel_mode,
    input wire update_hold,
    output reg serial_dout,
    output reg [`RD_WORD_W-1:0] relay_out_o,
    output reg [`RD_WORD_W-1:0] relay_out_oe,
    output reg update_ready,
    output reg update_lost
);
    wire [`RD_PIN_W-1:0] pins_raw;
    wire [`RD_PIN_W-1:0] pins;

    // every pin but update_hold is asynchronous to clk, so all ten pass the same two stages;
    // keeping them in one group keeps data aligned with the serial clock edge
    assign pins_raw = {parallel_mode, clear_all_n, set_all_n, switch_level,
                       channel_sel_bit2, channel_sel_bit1, channel_sel_bit0,
                       serial_din, chip_sel_n, serial_clk};

    relay_sync #(
        .W(`RD_PIN_W),
        .IDLE(`RD_PIN_IDLE)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in(pins_raw),
        .pin_sync(pins)
    );

    wire sclk_s = pins[`RD_PIN_SCLK];
    wire cs_s = pins[`RD_PIN_CS];
    wire din_s = pins[`RD_PIN_DIN];
    wire [`RD_SEL_W-1:0] sel_s = pins[`RD_PIN_SEL0 +: `RD_SEL_W];
    wire lvl_s = pins[`RD_PIN_LVL];
    wire set_s = ~pins[`RD_PIN_SET];
    wire clr_s = ~pins[`RD_PIN_CLR];
    wire par_mode_s = pins[`RD_PIN_MODE];

    reg sclk_prev_q;
    reg cs_prev_q;
    reg [`RD_WORD_W-1:0] shift_q;
    reg [`RD_WORD_W-1:0] shift_d;
    reg [`RD_PAR_W-1:0] par_q;
    reg [`RD_PAR_W-1:0] par_d;
    reg [`RD_WORD_W-1:0] latch_q;
    reg [`RD_WORD_W-1:0] latch_d;
    reg dout_d;

    // edges of the sampled serial clock and chip select
    wire sclk_rise = sclk_s & ~sclk_prev_q;
    wire sclk_fall = ~sclk_s & sclk_prev_q;
    wire cs_rise = cs_s & ~cs_prev_q;
    wire cs_fall = ~cs_s & cs_prev_q;
    wire shift_en = sclk_rise & ~cs_s;
    wire force_any = clr_s | set_s;

    // command queue between the chip select edge and the output latch
    wire cmd_ready;
    wire cmd_valid;
    wire [`RD_CMD_W-1:0] cmd_data;
    wire [`RD_CMD_W-1:0] cmd_in;
    wire cmd_push = cs_rise & ~force_any;
    wire cmd_pop = cmd_valid & ~update_hold;

    // the serial word is taken as it stands; in parallel mode the select and
    // level captured at the falling edge go in instead
    assign cmd_in = par_mode_s ? {1'b1, {(`RD_WORD_W-`RD_PAR_W){1'b0}}, par_q}
                               : {1'b0, shift_q};

    relay_fifo #(
        .WIDTH(`RD_CMD_W),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .flush(force_any),
        .in_valid(cmd_push),
        .in_ready(cmd_ready),
        .in_data(cmd_in),
        .out_valid(cmd_valid),
        .out_ready(~update_hold),
        .out_data(cmd_data)
    );

    wire cmd_is_par = cmd_data[`RD_CMD_KIND_BIT];
    wire [`RD_SEL_W-1:0] cmd_sel = cmd_data[`RD_SEL_W-1:0];
    wire cmd_lvl = cmd_data[`RD_PAR_LVL_BIT];

    // shift register and parallel capture register
    always @* begin
        shift_d = shift_q;
        par_d = par_q;
        if (clr_s) begin
            shift_d = `RD_ALL_OFF;
            par_d = `RD_PAR_OFF;
        end else if (set_s) begin
            shift_d = `RD_ALL_ON;
            par_d = `RD_PAR_ON;
        end else begin
            if (shift_en && !par_mode_s) begin
                // new bits enter at bit 0 so the first bit ends in bit 7;
                // older bits fall off the top, so only the last eight remain
                shift_d = {shift_q[`RD_WORD_W-2:0], din_s};
            end
            if (cs_fall && par_mode_s) begin
                // select and level are frozen when chip select falls, so later
                // changes on those pins do not reach the outputs
                par_d = {lvl_s, sel_s};
            end
        end
    end

    // output latch, fed only from the queue apart from the set and clear forces
    always @* begin
        latch_d = latch_q;
        if (clr_s) begin
            latch_d = `RD_ALL_OFF;
        end else if (set_s) begin
            latch_d = `RD_ALL_ON;
        end else if (cmd_pop) begin
            if (cmd_is_par) begin
                latch_d[cmd_sel] = cmd_lvl;
            end else begin
                latch_d = cmd_data[`RD_WORD_W-1:0];
            end
        end
    end

    // serial out: msb while deselected, last stage on each falling edge
    always @* begin
        dout_d = serial_dout;
        if (clr_s) begin
            dout_d = 1'b0;
        end else if (set_s) begin
            dout_d = 1'b1;
        end else if (cs_s) begin
            dout_d = shift_q[`RD_WORD_W-1];
        end else if (sclk_fall) begin
            dout_d = shift_q[`RD_WORD_W-1];
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
            shift_q <= `RD_ALL_OFF;
            par_q <= `RD_PAR_OFF;
            latch_q <= `RD_ALL_OFF;
            serial_dout <= 1'b0;
            relay_out_o <= `RD_ALL_OFF;
            relay_out_oe <= `RD_ALL_OFF;
            update_ready <= 1'b1;
            update_lost <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            cs_prev_q <= cs_s;
            shift_q <= shift_d;
            par_q <= par_d;
            // the latch changes only by a queued chip select rise or a force,
            // never by shifting
            latch_q <= latch_d;
            serial_dout <= dout_d;
            // open drain: the pin level is always low, the enable carries
            // the channel state so a one sinks to power ground
            relay_out_o <= `RD_ALL_OFF;
            relay_out_oe <= latch_d;
            update_ready <= cmd_ready;
            // the pins cannot be stalled, so a full queue drops the update
            update_lost <= cs_rise & ~force_any & ~cmd_ready;
        end
    end
endmodule

// ### relay_host.sv
module relay_host (
    output logic serial_clk,
    output logic chip_sel_n,
    output logic serial_din,
    input wire logic serial_dout
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] got;
    initial begin
        serial_clk = 0;
        chip_sel_n = 1;
        serial_din = 0;
    end
    // clock rests low between frames; data is inverted since nothing pulls it
    task automatic frame(input logic [15:0] w, input int n);
        got = '0;
        // one select line for this device alone, moved while the serial clock is low
        #10 chip_sel_n = 0;
        for (int i = n - 1; i >= 0; i--) begin
            #40 serial_din = w[i];
            #40 serial_clk = 1;
            // what the next device of a chain would shift in
            #40 got = {got[14:0], serial_dout};
            serial_clk = 0;
        end
        #40 chip_sel_n = 1;
        serial_din = ~serial_din;
    endtask
    // clock and data toggling with chip select high must leave the word alone
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            #40 serial_din = ~serial_din;
            serial_clk = 1;
            #40 serial_clk = 0;
        end
    endtask
endmodule

// ### relay_driver_props.sv
module relay_driver_props (
    input wire clk,
    input wire rst_n,
    input wire serial_clk,
    input wire chip_sel_n,
    input wire serial_din,
    input wire channel_sel_bit0,
    input wire channel_sel_bit1,
    input wire channel_sel_bit2,
    input wire switch_level,
    input wire set_all_n,
    input wire clear_all_n,
    input wire parallel_mode,
    input wire update_hold,
    input wire serial_dout,
    input wire [7:0] relay_out_o,
    input wire [7:0] relay_out_oe,
    input wire update_ready,
    input wire update_lost
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    od_level_a: assert property (relay_out_o == 8'h00)
        else $error("open-drain level driven high");
    clear_wins_a: assert property (!clear_all_n [*5] |-> relay_out_oe == 8'h00 && !serial_dout)
        else $error("clear did not force zeros");
    set_all_a: assert property ((!set_all_n && clear_all_n) [*6] |-> relay_out_oe == 8'hff)
        else $error("set did not force ones");
    latch_hold_a: assert property ((!update_hold && set_all_n && clear_all_n
        && $stable(chip_sel_n)) [*8] |-> $stable(relay_out_oe))
        else $error("channels moved without chip select rise");
    lost_pulse_a: assert property (update_lost |=> !update_lost)
        else $error("lost flag longer than one cycle");
    lost_full_a: assert property (update_lost |-> !$past(update_ready))
        else $error("update dropped with room in queue");
    lost_when_full_a: assert property ($rose(chip_sel_n) && !update_ready && update_hold
        && set_all_n && clear_all_n |-> ##[2:6] update_lost)
        else $error("full queue drop not flagged");
    reset_state_a: assert property ($rose(rst_n) |-> relay_out_oe == 8'h00 && update_ready)
        else $error("bad state after reset");
    cover property (update_lost);
    cover property ($rose(chip_sel_n) && parallel_mode);
    cover property (relay_out_oe == 8'hff);
endmodule

bind relay_driver relay_driver_props relay_driver_props_inst (.*);

// ### relay_driver_tb.sv
module relay_driver_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, serial_clk, chip_sel_n, serial_din, serial_dout;
    logic channel_sel_bit0 = 0, channel_sel_bit1 = 0, channel_sel_bit2 = 0, switch_level = 0;
    logic set_all_n = 1, clear_all_n = 1, parallel_mode = 0, update_hold = 0;
    logic update_ready, update_lost;
    logic [7:0] relay_out_o, relay_out_oe, cur = 0, sr = 0, seen = 0;
    logic [7:0] exp_q[$];
    int errors, compares, lost, cycles;
    integer seed = 32'h120a3289;
    relay_host relay_host_inst (.*);
    relay_driver #(.DEPTH(4), .AW(2)) relay_driver_inst (.*);
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (e !== s) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic close_out();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic note(input logic [7:0] v);
        if (v !== cur) exp_q.push_back(v);
        cur = v;
    endtask
    task automatic ser(input logic [15:0] w, input int n);
        logic [15:0] g;
        g = '0;
        relay_host_inst.frame(w, n);
        for (int i = n - 1; i >= 0; i--) begin
            g = {g[14:0], sr[7]};
            sr = {sr[6:0], w[i]};
        end
        chk("dout_bits", g, relay_host_inst.got);
        note(sr);
        repeat (8) @(negedge clk);
        chk("dout_idle", 16'(sr[7]), 16'(serial_dout));
    endtask
    task automatic par(input logic [2:0] idx, input logic lvl, input bit keep);
        logic [7:0] v;
        v = cur;
        v[idx] = lvl;
        {channel_sel_bit2, channel_sel_bit1, channel_sel_bit0} = idx;
        switch_level = lvl;
        if (keep) note(v);
        fork
            relay_host_inst.frame(16'h0000, 0);
            // garbage after the fall must not reach the channels
            #40 {channel_sel_bit2, channel_sel_bit1, channel_sel_bit0, switch_level} = ~{idx, lvl};
        join
        repeat (8) @(negedge clk);
    endtask
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
    always @(negedge clk) begin
        if (rst_n && update_lost === 1'b1) lost++;
        if (rst_n && relay_out_oe !== seen) begin
            if (exp_q.size() > 0)
                chk("oe", 16'(exp_q.pop_front()), 16'(relay_out_oe));
            else
                chk("oe_unexpected", 16'(seen), 16'(relay_out_oe));
            seen = relay_out_oe;
        end
    end
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1;
        repeat (3) @(negedge clk);
        for (int k = 0; k < 4; k++) ser(16'($random(seed)), 16);
        relay_host_inst.idle_clocks(3);
        ser(16'($random(seed)), 5);
        clear_all_n = 0;
        note(8'h00);
        sr = 8'h00;
        repeat (6) @(negedge clk);
        clear_all_n = 1;
        parallel_mode = 1;
        update_hold = 1;
        for (int k = 0; k < 5; k++) par(k[2:0], 1'b1, k < 4);
        chk("lost", 16'h1, 16'(lost));
        chk("ready_full", 16'h0, 16'(update_ready));
        update_hold = 0;
        repeat (10) @(negedge clk);
        chk("ready_free", 16'h1, 16'(update_ready));
        for (int k = 4; k < 8; k++) par(k[2:0], 1'b1, 1'b1);
        par(3'h0, 1'b0, 1'b1);
        clear_all_n = 0;
        note(8'h00);
        repeat (6) @(negedge clk);
        set_all_n = 0;
        repeat (6) @(negedge clk);
        clear_all_n = 1;
        note(8'hff);
        repeat (8) @(negedge clk);
        set_all_n = 1;
        repeat (8) @(negedge clk);
        chk("queue_left", 16'h0, 16'(exp_q.size()));
        chk("od_level", 16'h0, 16'(relay_out_o));
        close_out();
    end
endmodule
